/* ucs_pkg.sv */
/*
  ucs_pkg: register map, field positions and reset values of the usb core
  control and status block.
  assumes: a 32-bit apb register bus, one aligned word per register.
*/
package ucs_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] UCS_OFF_MAIN = 8'h00;   // main control/status, read clears endpoint flags
  localparam logic [7:0] UCS_OFF_IRQ_STAT = 8'h04;
  localparam logic [7:0] UCS_OFF_IRQ_MASK = 8'h08;
  localparam logic [7:0] UCS_OFF_PEEK = 8'h0C;   // same word without the flag byte, no side effect

  // ****************************************
  // main word field positions
  // ****************************************
  localparam int UCS_EP_TX_LSB = 17;
  localparam int UCS_EP_TX_MSB = 23;
  localparam int UCS_EP0_BIT = 16;
  localparam int UCS_ISO_BIT = 15;
  localparam int UCS_CONN_BIT = 14;
  localparam int UCS_FAST_SPEED_ENABLE_BIT = 13;
  localparam int UCS_HSACT_BIT = 12;
  localparam int UCS_RST_BIT = 11;
  localparam int UCS_FADDR_MSB = 6;
  localparam int UCS_FADDR_W = 7;
  localparam int UCS_NUM_TX_EP = 7;

  // ****************************************
  // interrupt status bit positions
  // ****************************************
  localparam int UCS_IRQ_EP = 0;
  localparam int UCS_IRQ_SOF = 1;
  localparam int UCS_IRQ_BUSRST = 2;
  localparam int UCS_IRQ_FAST = 3;
  localparam int UCS_IRQ_W = 4;

  // ****************************************
  // values after reset
  // ****************************************
  localparam logic UCS_RST_ISO = 1'b0;
  localparam logic UCS_RST_CONN = 1'b0;
  localparam logic UCS_RST_FAST_SPEED_ENABLE = 1'b1;
  localparam logic [6:0] UCS_RST_FADDR = 7'h00;
  localparam logic [3:0] UCS_RST_IRQ_MASK = 4'h0;

  // endpoint flag byte: seven transmit flags above the endpoint-zero flag
  function automatic logic [7:0] ucs_flag_byte(input logic [6:0] tx, input logic ep0);
    ucs_flag_byte = {tx, ep0};
  endfunction : ucs_flag_byte

endpackage : ucs_pkg

/* ucs_iso_if.sv */
/*
  ucs_iso_if: carries transmit-ready events and send releases between the
  control block and its isochronous send gate.
  assumes: both ends on the same clock.
*/
`timescale 1ns/100ps
interface ucs_iso_if #(parameter int N = 8);
  logic [N-1:0] loaded;     // one-cycle pulse: packet loaded for endpoint
  logic [N-1:0] iso_ep;     // level: endpoint runs isochronous
  logic wait_en;            // level: hold iso packets for frame start
  logic sof;                // one-cycle pulse: frame start token
  logic [N-1:0] send;       // one-cycle pulse: packet may go out
  modport ctrl (output loaded, output iso_ep, output wait_en, output sof, input send);
  modport gate (input loaded, input iso_ep, input wait_en, input sof, output send);
endinterface : ucs_iso_if

/* ucs_sync.sv */
/*
  ucs_sync: three-stage synchroniser with agreement filter for a pin.
  assumes: the input is asynchronous to pclk.
*/
`timescale 1ns/100ps
module ucs_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic sync_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // ****************************************
  // shift chain; first stage feeds only the second
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_out <= 1'b0;
    end else if (s2_q == s3_q) begin
      sync_out <= s3_q;
    end
  end
endmodule : ucs_sync

/* ucs_iso_gate.sv */
/*
  ucs_iso_gate: holds isochronous packets until the next frame start when
  asked to, otherwise releases each packet the cycle after it is loaded.
  assumes: loaded and sof are single-cycle pulses on pclk.
*/
`timescale 1ns/100ps
module ucs_iso_gate (
  input wire logic pclk,
  input wire logic presetn,
  ucs_iso_if.gate iso
);
  localparam int N = $bits(iso.loaded);
  logic [N-1:0] hold_q;
  logic [N-1:0] send_q;
  logic [N-1:0] hold_new;

  // packets that must wait for the frame start
  assign hold_new = iso.loaded & iso.iso_ep & {N{iso.wait_en}};

  // ****************************************
  // held packets; a load in the sof cycle waits for the next one
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= '0;
    end else if (iso.sof) begin
      hold_q <= hold_new;
    end else begin
      hold_q <= hold_q | hold_new;
    end
  end

  // release: immediate when not held, else at sof
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      send_q <= '0;
    end else begin
      send_q <= (iso.loaded & ~hold_new) | (hold_q & {N{iso.sof}});
    end
  end

  assign iso.send = send_q;
endmodule : ucs_iso_gate

/* ucs_top.sv */
/*
  ucs_top: control and status of an on-chip usb controller behind apb.
  holds the endpoint interrupt flags (cleared by a full read of the main
  word), isochronous send timing, soft connect, fast speed enable and
  negotiation status, bus reset status, function address and a maskable
  interrupt.
  assumes: link events arrive as pclk pulses from the protocol engine; the
  bus reset indication and the host/peripheral role are asynchronous pins.
*/
// How it works
// - top byte of main word reads zero
// - seven endpoint transmit flags, hardware set
// - endpoint zero flag, hardware set
// - reading the flag byte clears all flags
// - iso wait: hold loaded packet until sof
// - iso wait only peripheral iso endpoints
// - connect bit drives bus lines, resets zero
// - fast speed enable resets one, negotiates
// - fast speed status valid after reset end
// - reset status; host mode software drives reset
`timescale 1ns/100ps
module ucs_top #(
  parameter int NUM_TX_EP = ucs_pkg::UCS_NUM_TX_EP
) (
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // role and bus pins
  input wire logic host_mode_pin,
  input wire logic bus_reset_pin,
  // protocol engine events, pclk domain
  input wire logic [NUM_TX_EP-1:0] ep_tx_event,
  input wire logic ep0_event,
  input wire logic sof_token,
  input wire logic fast_handshake_ok,
  input wire logic [NUM_TX_EP:0] transmit_packet_loaded,
  input wire logic [NUM_TX_EP:0] ep_is_iso,
  // controls toward the link
  output logic [NUM_TX_EP:0] tx_send,
  output logic bus_line_oe,
  output logic fast_speed_enable_o,
  output logic host_bus_reset_drive,
  output logic irq
);
  import ucs_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic host_mode;
  logic bus_reset_sync;
  logic bus_reset_prev_q;
  logic [NUM_TX_EP-1:0] endpoint_tx_flags_q;
  logic control_endpoint_flag_q;
  logic iso_wait_frame_start_q;
  logic bus_line_connect_q;
  logic fast_speed_enable_q;
  logic fast_speed_active_q;
  logic fast_pending_q;
  logic host_reset_q;
  logic [UCS_FADDR_W-1:0] function_address_q;
  logic [UCS_IRQ_W-1:0] irq_stat_q;
  logic [UCS_IRQ_W-1:0] irq_mask_q;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic hit_main;
  logic hit_stat;
  logic hit_mask;
  logic hit_peek;
  logic mapped;
  logic flag_clear;
  logic reset_status;
  logic reset_start;
  logic reset_end;
  logic host_reset_release;
  logic [UCS_IRQ_W-1:0] irq_events;
  logic [31:0] main_word;
  logic [31:0] rd_word;

  ucs_iso_if #(.N(NUM_TX_EP + 1)) iso_bus ();

  // ****************************************
  // pin synchronisers
  // ****************************************
  // role pin may move at any time, so it is filtered like the bus pin
  ucs_sync u_sync_role (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(host_mode_pin),
    .sync_out(host_mode)
  );

  ucs_sync u_sync_bus_reset (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(bus_reset_pin),
    .sync_out(bus_reset_sync)
  );

  // ****************************************
  // apb decode
  // ****************************************
  // register offsets are word aligned; the low address bits are ignored
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    addr_is = (a[7:2] == off[7:2]);
  endfunction : addr_is

  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign hit_main = addr_is(paddr, UCS_OFF_MAIN);
  assign hit_stat = addr_is(paddr, UCS_OFF_IRQ_STAT);
  assign hit_mask = addr_is(paddr, UCS_OFF_IRQ_MASK);
  assign hit_peek = addr_is(paddr, UCS_OFF_PEEK);
  assign mapped = hit_main | hit_stat | hit_mask | hit_peek;

  // full-word read of the main word covers the flag byte and clears it;
  // the peek alias leaves that lane out so status reads are harmless
  assign flag_clear = rd & hit_main;

  // ****************************************
  // apb handshake: one setup, one access cycle
  // ****************************************
  // pready registered so the slave answers from a flop, never a gate chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // unmapped offsets answer with an error and touch nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup & ~mapped;
    end
  end

  // ****************************************
  // bus reset tracking
  // ****************************************
  // peripheral: bus pin; host: software drives it
  assign reset_status = host_mode ? host_reset_q : bus_reset_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_reset_prev_q <= 1'b0;
    end else begin
      bus_reset_prev_q <= bus_reset_sync;
    end
  end

  assign reset_start = ~host_mode & bus_reset_sync & ~bus_reset_prev_q;
  assign reset_end = ~host_mode & ~bus_reset_sync & bus_reset_prev_q;
  assign host_reset_release = host_mode & host_reset_q & wr & hit_main & pstrb[1] & ~pwdata[UCS_RST_BIT];

  // host mode reset bit, writable only while acting as host
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_reset_q <= 1'b0;
    end else if (!host_mode) begin
      host_reset_q <= 1'b0;
    end else if (wr && hit_main && pstrb[1]) begin
      host_reset_q <= pwdata[UCS_RST_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_bus_reset_drive <= 1'b0;
    end else begin
      host_bus_reset_drive <= host_mode & host_reset_q;
    end
  end

  // ****************************************
  // endpoint interrupt flags
  // ****************************************
  // a new event in the clearing cycle survives: set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      endpoint_tx_flags_q <= '0;
    end else begin
      endpoint_tx_flags_q <= (endpoint_tx_flags_q & {NUM_TX_EP{~flag_clear}}) | ep_tx_event;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_endpoint_flag_q <= 1'b0;
    end else begin
      control_endpoint_flag_q <= (control_endpoint_flag_q & ~flag_clear) | ep0_event;
    end
  end

  // ****************************************
  // control bits
  // ****************************************
  // iso wait has no storage in host mode and reads zero there
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iso_wait_frame_start_q <= UCS_RST_ISO;
    end else if (host_mode) begin
      iso_wait_frame_start_q <= 1'b0;
    end else if (wr && hit_main && pstrb[1]) begin
      iso_wait_frame_start_q <= pwdata[UCS_ISO_BIT];
    end
  end

  // soft connect, peripheral only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_line_connect_q <= UCS_RST_CONN;
    end else if (host_mode) begin
      bus_line_connect_q <= 1'b0;
    end else if (wr && hit_main && pstrb[1]) begin
      bus_line_connect_q <= pwdata[UCS_CONN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_speed_enable_q <= UCS_RST_FAST_SPEED_ENABLE;
    end else if (wr && hit_main && pstrb[1]) begin
      fast_speed_enable_q <= pwdata[UCS_FAST_SPEED_ENABLE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      function_address_q <= UCS_RST_FADDR;
    end else if (wr && hit_main && pstrb[0]) begin
      function_address_q <= pwdata[UCS_FADDR_MSB:0];
    end
  end

  // line drivers follow the connect bit; low means tri-stated lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_line_oe <= 1'b0;
    end else begin
      bus_line_oe <= bus_line_connect_q & ~host_mode;
    end
  end

  // with the enable low the link may not chirp: full speed only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_speed_enable_o <= UCS_RST_FAST_SPEED_ENABLE;
    end else begin
      fast_speed_enable_o <= fast_speed_enable_q;
    end
  end

  // ****************************************
  // fast speed negotiation
  // ****************************************
  // handshake only counts while reset is on the bus and the enable is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_pending_q <= 1'b0;
    end else if (reset_start) begin
      fast_pending_q <= 1'b0;
    end else if (fast_handshake_ok && reset_status && fast_speed_enable_q) begin
      fast_pending_q <= 1'b1;
    end
  end

  // status is published only when the reset is over, so it never shows
  // a half-finished negotiation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_speed_active_q <= 1'b0;
    end else if (reset_start) begin
      fast_speed_active_q <= 1'b0;
    end else if (reset_end || host_reset_release) begin
      fast_speed_active_q <= fast_pending_q;
    end
  end

  // ****************************************
  // interrupt status and mask
  // ****************************************
  assign irq_events[UCS_IRQ_EP] = (|ep_tx_event) | ep0_event;
  assign irq_events[UCS_IRQ_SOF] = sof_token;
  assign irq_events[UCS_IRQ_BUSRST] = reset_start;
  assign irq_events[UCS_IRQ_FAST] = (reset_end | host_reset_release) & fast_pending_q;

  // write one to clear; an event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
    end else if (wr && hit_stat && pstrb[0]) begin
      irq_stat_q <= (irq_stat_q & ~pwdata[UCS_IRQ_W-1:0]) | irq_events;
    end else begin
      irq_stat_q <= irq_stat_q | irq_events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= UCS_RST_IRQ_MASK;
    end else if (wr && hit_mask && pstrb[0]) begin
      irq_mask_q <= pwdata[UCS_IRQ_W-1:0];
    end
  end

  // one cycle behind the status; keeps the output on a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ****************************************
  // isochronous send gate
  // ****************************************
  assign iso_bus.loaded = transmit_packet_loaded;
  assign iso_bus.iso_ep = ep_is_iso;
  assign iso_bus.wait_en = iso_wait_frame_start_q & ~host_mode;
  assign iso_bus.sof = sof_token;

  ucs_iso_gate u_iso_gate (
    .pclk(pclk),
    .presetn(presetn),
    .iso(iso_bus.gate)
  );

  assign tx_send = iso_bus.send;

  // ****************************************
  // read data
  // ****************************************
  // top byte and bits 10..7 are unimplemented and read zero
  always_comb begin
    main_word = 32'h0000_0000;
    main_word[UCS_EP_TX_MSB:UCS_EP0_BIT] = ucs_flag_byte(endpoint_tx_flags_q, control_endpoint_flag_q);
    main_word[UCS_ISO_BIT] = iso_wait_frame_start_q;
    main_word[UCS_CONN_BIT] = bus_line_connect_q;
    main_word[UCS_FAST_SPEED_ENABLE_BIT] = fast_speed_enable_q;
    main_word[UCS_HSACT_BIT] = fast_speed_active_q;
    main_word[UCS_RST_BIT] = reset_status;
    main_word[UCS_FADDR_MSB:0] = function_address_q;
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_main) begin
      rd_word = main_word;
    end else if (hit_peek) begin
      rd_word = main_word & 32'hFF00_FFFF;
    end else if (hit_stat) begin
      rd_word[UCS_IRQ_W-1:0] = irq_stat_q;
    end else if (hit_mask) begin
      rd_word[UCS_IRQ_W-1:0] = irq_mask_q;
    end
  end

  // captured in setup so the access cycle returns it from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= rd_word;
    end else if (access) begin
      prdata <= 32'h0000_0000;
    end
  end

endmodule : ucs_top

/* ucs_props.sv */
/*
  ucs_props: concurrent checks on the ports of ucs_top, bound to it.
  assumes: single pclk domain, presetn asynchronous active low.
*/
`timescale 1ns/100ps
module ucs_props
  import ucs_pkg::*;
#(
  parameter int NUM_TX_EP = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic host_mode_pin,
  input wire logic sof_token,
  input wire logic [NUM_TX_EP:0] transmit_packet_loaded,
  input wire logic [NUM_TX_EP:0] ep_is_iso,
  input wire logic [NUM_TX_EP:0] tx_send,
  input wire logic bus_line_oe,
  input wire logic fast_speed_enable_o,
  input wire logic host_bus_reset_drive
);
  // ****************************************
  // sequences
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // read access cycle; eight cycles of a role cover the pin synchroniser
  sequence s_rd;
    pready && !pwrite;
  endsequence
  sequence s_host;
    host_mode_pin [*8];
  endsequence
  sequence s_per;
    !host_mode_pin [*8];
  endsequence

  // ****************************************
  // assertions
  // ****************************************
  AST_TOP_ZERO: assert property (s_rd |-> prdata[31:24] == 8'h00)
    else $error("top byte of read data not zero");
  AST_BIT7_ZERO: assert property (s_rd |-> !prdata[7])
    else $error("bit seven of read data set");
  AST_PEEK_SAFE: assert property (s_rd ##0 paddr == UCS_OFF_PEEK |-> prdata[23:16] == 8'h00)
    else $error("peek alias shows flag byte");
  AST_SEND_NOW: assert property (transmit_packet_loaded[0] && !ep_is_iso[0] |=> tx_send[0])
    else $error("non-iso packet not released next cycle");
  AST_SEND_CAUSE: assert property (tx_send[1] |-> $past(transmit_packet_loaded[1]) || $past(sof_token))
    else $error("release without load or frame start");
  AST_HOST_ISO: assert property (s_host ##0 transmit_packet_loaded[1] |=> tx_send[1])
    else $error("host role held an iso packet");
  AST_HOST_OFF: assert property (s_host |-> !bus_line_oe)
    else $error("bus lines driven in host role");
  AST_PER_NODRV: assert property (s_per |-> !host_bus_reset_drive)
    else $error("bus reset driven in peripheral role");
  AST_RST_VAL: assert property ($rose(presetn) |-> fast_speed_enable_o && !bus_line_oe)
    else $error("wrong control outputs after reset");
endmodule : ucs_props

bind ucs_top ucs_props #(.NUM_TX_EP(NUM_TX_EP)) i_props (
  .pclk(pclk),
  .presetn(presetn),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .host_mode_pin(host_mode_pin),
  .sof_token(sof_token),
  .transmit_packet_loaded(transmit_packet_loaded),
  .ep_is_iso(ep_is_iso),
  .tx_send(tx_send),
  .bus_line_oe(bus_line_oe),
  .fast_speed_enable_o(fast_speed_enable_o),
  .host_bus_reset_drive(host_bus_reset_drive)
);

/* ucs_host_model.sv */
/*
  ucs_host_model: behavioural usb host or hub on the bus side.
  assumes: pclk pulses toward the block; bus reset started by the bench.
*/
`timescale 1ns/100ps
module ucs_host_model #(
  parameter int SOF_GAP = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic bus_reset_pin,
  output logic sof_token,
  output logic fast_handshake_ok
);
  int cnt_q;

  // frame start every SOF_GAP cycles, none during reset signalling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 0;
      sof_token <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == SOF_GAP - 1) ? 0 : cnt_q + 1;
      sof_token <= (cnt_q == SOF_GAP - 1) && !bus_reset_pin;
    end
  end

  // idle bus at time zero
  initial begin
    bus_reset_pin = 1'b0;
    fast_handshake_ok = 1'b0;
  end

  // hub answers the chirp mid reset even if the device did not ask
  task automatic bus_reset(input int len);
    @(posedge pclk);
    bus_reset_pin <= 1'b1;
    repeat (len / 2) @(posedge pclk);
    fast_handshake_ok <= 1'b1;
    @(posedge pclk);
    fast_handshake_ok <= 1'b0;
    repeat (len / 2) @(posedge pclk);
    bus_reset_pin <= 1'b0;
  endtask : bus_reset
endmodule : ucs_host_model

/* tb_top.sv */
/*
  tb_top: self-checking bench for ucs_top with an apb master and a host model.
  assumes: ucs_pkg map; one apb transfer at a time.
*/
`timescale 1ns/100ps
module tb_top;
  import ucs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready, irq, er, s;
  logic [7:0] paddr, ld, iso;
  logic [31:0] pwdata, prdata, rd, w;
  logic [3:0] pstrb;
  logic host_mode_pin, bus_reset_pin, ep0_event, sof_token, fast_handshake_ok;
  logic [6:0] ep_tx_event, ev;
  logic [7:0] tx_send;
  logic bus_line_oe, fast_speed_enable_o, host_bus_reset_drive;
  int miscompares, total_checks, n;

  ucs_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_mode_pin(host_mode_pin), .bus_reset_pin(bus_reset_pin), .ep_tx_event(ep_tx_event),
    .ep0_event(ep0_event), .sof_token(sof_token), .fast_handshake_ok(fast_handshake_ok),
    .transmit_packet_loaded(ld), .ep_is_iso(iso), .tx_send(tx_send), .bus_line_oe(bus_line_oe),
    .fast_speed_enable_o(fast_speed_enable_o), .host_bus_reset_drive(host_bus_reset_drive), .irq(irq));
  ucs_host_model i_host (.pclk(pclk), .presetn(presetn), .bus_reset_pin(bus_reset_pin),
    .sof_token(sof_token), .fast_handshake_ok(fast_handshake_ok));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  // main word as it should read back; bits 10..7 hold nothing here
  function automatic logic [31:0] exp_main(input logic [31:0] d, input logic hs, input logic rst);
    return {16'h0000, d[15:13], hs, rst, 4'h0, d[6:0]};
  endfunction : exp_main
  // one transfer; data taken at the edge that samples pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one-cycle event pulses, then a look at the first cycle after them
  task automatic pulse(input logic [6:0] e, input logic e0, input logic [7:0] l);
    @(posedge pclk);
    ep_tx_event <= e;
    ep0_event <= e0;
    ld <= l;
    @(posedge pclk);
    ep_tx_event <= 7'h00;
    ep0_event <= 1'b0;
    ld <= 8'h00;
    #1;
  endtask : pulse
  task automatic stop_test;
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // ****************************************
  // clock, watchdog, tests
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // about 300 cycles expected; generous margin
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    $display("MISMATCH %0t timeout", $time);
    stop_test;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, host_mode_pin, ep0_event} = '0;
    {ep_tx_event, ld, iso} = '0;
    pstrb = 4'hF;
    void'($urandom(33489));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, UCS_OFF_PEEK, 32'h0);
    chk(rd, 32'h0000_2000, "main reset value");
    apb(1'b0, UCS_OFF_IRQ_MASK, 32'h0);
    chk(rd, 32'h0, "mask reset value");
    for (int i = 0; i < 4; i++) begin
      w = $urandom;
      apb(1'b1, UCS_OFF_MAIN, w);
      apb(1'b0, UCS_OFF_PEEK, 32'h0);
      chk(rd, exp_main(w, 1'b0, 1'b0), "main read back");
      chk({31'h0, bus_line_oe}, {31'h0, w[14]}, "bus line enable");
      chk({31'h0, fast_speed_enable_o}, {31'h0, w[13]}, "fast enable out");
    end
    pstrb <= 4'h1;
    apb(1'b1, UCS_OFF_MAIN, 32'h0);
    pstrb <= 4'hF;
    apb(1'b0, UCS_OFF_PEEK, 32'h0);
    chk(rd & 32'hE07F, w & 32'hE000, "lane strobes");
    apb(1'b1, UCS_OFF_MAIN, 32'h0000_E055);
    ev = 7'($urandom_range(127, 1));
    pulse(ev, 1'b1, 8'h00);
    apb(1'b0, UCS_OFF_PEEK, 32'h0);
    chk(rd & 32'h00FF_0000, 32'h0, "peek shows flags");
    apb(1'b0, UCS_OFF_MAIN, 32'h0);
    chk(rd & 32'h00FF_0000, {8'h00, ev, 1'b1, 16'h0000}, "endpoint flags");
    apb(1'b0, UCS_OFF_MAIN, 32'h0);
    chk(rd & 32'h00FF_0000, 32'h0, "flags not cleared");
    apb(1'b0, UCS_OFF_IRQ_STAT, 32'h0);
    chk(rd & 32'h1, 32'h1, "endpoint irq status");
    chk({31'h0, irq}, 32'h0, "masked irq");
    apb(1'b1, UCS_OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1, "unmasked irq");
    apb(1'b1, UCS_OFF_IRQ_STAT, 32'hF);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0, "irq after clear");
    apb(1'b0, 8'h10, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000, "unmapped access");
    // iso hold: ep1 iso waits for frame start, ep2 goes at once
    @(posedge pclk);
    iso <= 8'h02;
    do begin
      @(posedge pclk);
      #1;
    end while (sof_token !== 1'b1);
    pulse(7'h00, 1'b0, 8'h07);
    chk(32'(tx_send & 8'h07), 32'h5, "release pattern");
    s = 1'b0;
    for (n = 0; n < 100 && tx_send[1] !== 1'b1; n++) begin
      s = sof_token;
      @(posedge pclk);
      #1;
    end
    chk({31'h0, tx_send[1]}, 32'h1, "held packet never sent");
    chk({31'h0, s}, 32'h1, "held packet not tied to frame start");
    apb(1'b1, UCS_OFF_MAIN, 32'h0000_6055);
    pulse(7'h00, 1'b0, 8'h02);
    chk({31'h0, tx_send[1]}, 32'h1, "iso without wait");
    // host role: iso wait and connect gone, reset bit writable
    @(posedge pclk);
    host_mode_pin <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b1, UCS_OFF_MAIN, 32'h0000_E855);
    apb(1'b0, UCS_OFF_PEEK, 32'h0);
    chk(rd, exp_main(32'h0000_2055, 1'b0, 1'b1), "host main word");
    chk({31'h0, host_bus_reset_drive}, 32'h1, "host reset drive");
    pulse(7'h00, 1'b0, 8'h02);
    chk({31'h0, tx_send[1]}, 32'h1, "host iso release");
    apb(1'b1, UCS_OFF_MAIN, 32'h0000_2055);
    repeat (2) @(posedge pclk);
    chk({31'h0, host_bus_reset_drive}, 32'h0, "host reset release");
    @(posedge pclk);
    host_mode_pin <= 1'b0;
    repeat (10) @(posedge pclk);
    // bus reset from the hub, fast enable on then off
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, UCS_OFF_MAIN, k ? 32'h0000_4055 : 32'h0000_6055);
      fork
        i_host.bus_reset(30);
        begin
          repeat (14) @(posedge pclk);
          apb(1'b0, UCS_OFF_PEEK, 32'h0);
          chk(rd & 32'h0800, 32'h0800, "reset status");
        end
      join
      repeat (8) @(posedge pclk);
      apb(1'b0, UCS_OFF_PEEK, 32'h0);
      chk(rd & 32'h3800, k ? 32'h0 : 32'h3000, "fast speed result");
    end
    stop_test;
  end
endmodule : tb_top
